// ===== shared/sup_pkg.sv
// Shared constants and types for the reset supervisor and its input filters.
// Assumes a single 40 MHz clock; all intervals are derived from it.
package sup_pkg;
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
	localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;

	// Times as printed, each in its own unit
	localparam int unsigned WATCHDOG_PERIOD_MS          = 1600;
	localparam int unsigned POWER_UP_RESET_TIMEOUT_MS   = 200;
	localparam int unsigned POWER_UP_RESET_MIN_MS       = 130;
	localparam int unsigned POWER_UP_RESET_MAX_MS       = 270;
	localparam int unsigned WRITE_CYCLE_TIME_MS         = 10;
	localparam int unsigned THRESHOLD_TO_RESET_DELAY_US = 5;
	localparam int unsigned GLITCH_REJECT_WIDTH_NS      = 100;
	localparam int unsigned NOISE_REJECT_WIDTH_NS       = 200;

	// Derived cycle counts
	localparam int unsigned WDOG_CYCLES   = WATCHDOG_PERIOD_MS * CYC_PER_MS;
	localparam int unsigned RST_CYCLES    = POWER_UP_RESET_TIMEOUT_MS * CYC_PER_MS;
	localparam int unsigned WR_CYCLES     = WRITE_CYCLE_TIME_MS * CYC_PER_MS;
	localparam int unsigned TRD_CYCLES    = THRESHOLD_TO_RESET_DELAY_US * CYC_PER_US;
	localparam int unsigned GLITCH_CYCLES = (GLITCH_REJECT_WIDTH_NS * CYC_PER_US) / 1000;
	localparam int unsigned NOISE_CYCLES  = (NOISE_REJECT_WIDTH_NS * CYC_PER_US) / 1000;

	localparam int unsigned CNT_W  = 27;
	localparam int unsigned FCNT_W = 4;

	// Reset values of the filtered pins (reset pins seen asserted)
	localparam logic RST_HI_INIT = 1'b1;
	localparam logic RST_LO_INIT = 1'b0;

	typedef enum logic [2:0] {
		ST_POWER   = 3'b001,
		ST_TIMEOUT = 3'b010,
		ST_RUN     = 3'b100
	} sup_state_t;

	// Requests from the serial protocol engine
	typedef struct packed {
		logic write_stop;
		logic ack_addr;
		logic ack_wdata;
		logic drive_low;
	} eng_req_t;

	// Status returned to the serial protocol engine
	typedef struct packed {
		logic access_ok;
		logic write_busy;
	} eng_stat_t;

	typedef struct packed {
		logic              s1;
		logic              s2;
		logic              s3;
		logic [FCNT_W-1:0] cnt;
		logic              out;
	} filt_state_t;

	typedef struct packed {
		sup_state_t       st;
		logic [CNT_W-1:0] tmo;
		logic [CNT_W-1:0] wdog;
		logic [CNT_W-1:0] wr;
		logic             kick_q;
		logic             rhi_q;
		logic             rlo_q;
		logic             sup1;
		logic             sup2;
		logic             sup3;
		logic             sup_ok;
		logic             rst_oe;
		logic             sda_oe;
		logic             zero;
		eng_stat_t        stat;
	} sup_regs_t;
endpackage

// ===== core/pin_filter.sv
// Pin synchroniser and glitch filter for one asynchronous input.
// Assumes the pin is unrelated to clk; output follows only after STABLE + 1 agreeing samples.
`timescale 1ns/1ps
module pin_filter #(
	parameter int unsigned STABLE = 5,
	parameter logic        INIT   = 1'b0
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic pin,
	output logic      filt
);
	import sup_pkg::*;

	filt_state_t r;
	filt_state_t nxt;

	always_comb begin
		nxt    = r;
		nxt.s1 = pin;
		nxt.s2 = r.s1;
		nxt.s3 = r.s2;
		if (r.s2 == r.s3 && r.s3 != r.out) begin
			if (r.cnt == FCNT_W'(STABLE - 1)) begin
				nxt.out = r.s3;
				nxt.cnt = '0;
			end else begin
				nxt.cnt = r.cnt + FCNT_W'(1);
			end
		end else begin
			nxt.cnt = '0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r <= '{s1: INIT, s2: INIT, s3: INIT, cnt: '0, out: INIT};
		end else begin
			r <= nxt;
		end
	end

	assign filt = r.out;

	AST_FILT_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		(r.s2 != r.s3) |=> $stable(r.out))
		else $error("filter output moved on disagreeing samples");
endmodule

// ===== core/supervisor_reset_watchdog_lockout.sv
// Reset supervisor, watchdog and memory write lockout of a serial memory companion.
// Assumes an analog comparator drives supply_ok and a serial engine on clk uses eng_req/eng_stat.
`timescale 1ns/1ps
module supervisor_reset_watchdog_lockout #(
	parameter int unsigned WDOG_CYC = sup_pkg::WDOG_CYCLES,
	parameter int unsigned RST_CYC  = sup_pkg::RST_CYCLES,
	parameter int unsigned WR_CYC   = sup_pkg::WR_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        supply_ok,
	input  wire logic        watchdog_kick_input,
	input  wire logic        write_protect,
	input  wire logic        rst_hi_i,
	output logic             rst_hi_o,
	output logic             rst_hi_oe,
	input  wire logic        rst_lo_n_i,
	output logic             rst_lo_n_o,
	output logic             rst_lo_n_oe,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             scl_filt,
	output logic             sda_filt,
	input  wire sup_pkg::eng_req_t  eng_req,
	output sup_pkg::eng_stat_t      eng_stat
);
	import sup_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sup_regs_t r;
	sup_regs_t nxt;
	logic      kick_f;
	logic      wp_f;
	logic      hi_f;
	logic      lo_f;
	logic      kick;
	logic      man;
	logic      wd_fire;

	// Pin conditioning
	pin_filter #(.STABLE(GLITCH_CYCLES + 1), .INIT(RST_HI_INIT)) u_hi (
		.clk    (clk),
		.resetn (resetn),
		.pin    (rst_hi_i),
		.filt   (hi_f)
	);
	pin_filter #(.STABLE(GLITCH_CYCLES + 1), .INIT(RST_LO_INIT)) u_lo (
		.clk    (clk),
		.resetn (resetn),
		.pin    (rst_lo_n_i),
		.filt   (lo_f)
	);
	pin_filter #(.STABLE(GLITCH_CYCLES + 1), .INIT(1'b0)) u_kick (
		.clk    (clk),
		.resetn (resetn),
		.pin    (watchdog_kick_input),
		.filt   (kick_f)
	);
	pin_filter #(.STABLE(GLITCH_CYCLES + 1), .INIT(1'b0)) u_wp (
		.clk    (clk),
		.resetn (resetn),
		.pin    (write_protect),
		.filt   (wp_f)
	);
	pin_filter #(.STABLE(NOISE_CYCLES + 1), .INIT(1'b1)) u_scl (
		.clk    (clk),
		.resetn (resetn),
		.pin    (scl_i),
		.filt   (scl_filt)
	);
	pin_filter #(.STABLE(NOISE_CYCLES + 1), .INIT(1'b1)) u_sda (
		.clk    (clk),
		.resetn (resetn),
		.pin    (sda_i),
		.filt   (sda_filt)
	);

	always_comb begin
		nxt        = r;
		nxt.sup1   = supply_ok;
		nxt.sup2   = r.sup1;
		nxt.sup3   = r.sup2;
		if (r.sup2 == r.sup3) begin
			nxt.sup_ok = r.sup3;
		end
		nxt.kick_q = kick_f;
		nxt.rhi_q  = hi_f;
		nxt.rlo_q  = lo_f;
		kick       = kick_f != r.kick_q;
		// Own drive is ignored; only outside edges count
		man        = !r.rst_oe && ((hi_f && !r.rhi_q) || (!lo_f && r.rlo_q));
		wd_fire    = r.st == ST_RUN && !kick && r.wdog == CNT_W'(WDOG_CYC - 1);

		case (r.st)
			ST_POWER: begin
				nxt.tmo = '0;
				if (r.sup_ok) begin
					nxt.st = ST_TIMEOUT;
				end
			end
			ST_TIMEOUT: begin
				if (r.tmo == CNT_W'(RST_CYC - 1)) begin
					nxt.st  = ST_RUN;
					nxt.tmo = '0;
				end else begin
					nxt.tmo = r.tmo + CNT_W'(1);
				end
			end
			ST_RUN: begin
				if (man || wd_fire) begin
					nxt.st  = ST_TIMEOUT;
					nxt.tmo = '0;
				end
			end
			default: begin
				nxt.st  = ST_POWER;
				nxt.tmo = '0;
			end
		endcase
		if (!r.sup_ok) begin
			nxt.st  = ST_POWER;
			nxt.tmo = '0;
		end

		if (r.st != ST_RUN || kick || wd_fire) begin
			nxt.wdog = '0;
		end else begin
			nxt.wdog = r.wdog + CNT_W'(1);
		end

		if (r.stat.write_busy) begin
			if (r.wr == CNT_W'(WR_CYC - 1)) begin
				nxt.stat.write_busy = 1'b0;
				nxt.wr              = '0;
			end else begin
				nxt.wr = r.wr + CNT_W'(1);
			end
		end else if (eng_req.write_stop && r.stat.access_ok && !wp_f) begin
			nxt.stat.write_busy = 1'b1;
			nxt.wr              = '0;
		end

		nxt.rst_oe         = nxt.st != ST_RUN;
		nxt.stat.access_ok = nxt.st == ST_RUN && !nxt.stat.write_busy;
		nxt.sda_oe         = r.stat.access_ok
			&& (eng_req.ack_addr || eng_req.drive_low || (eng_req.ack_wdata && !wp_f));
		nxt.zero           = 1'b0;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r        <= '0;
			r.st     <= ST_POWER;
			r.rhi_q  <= RST_HI_INIT;
			r.rlo_q  <= RST_LO_INIT;
			r.rst_oe <= 1'b1;
		end else begin
			r <= nxt;
		end
	end

	// Single-level drivers: high pin driven high and pulled down outside, low pin driven low and pulled up
	assign rst_hi_o    = r.rst_oe;
	assign rst_hi_oe   = r.rst_oe;
	assign rst_lo_n_o  = r.zero;
	assign rst_lo_n_oe = r.rst_oe;
	assign sda_o       = r.zero;
	assign sda_oe      = r.sda_oe;
	assign eng_stat    = r.stat;

	AST_WDOG_CLEAR: assert property (r.st == ST_RUN && $changed(kick_f) |=> r.wdog == '0)
		else $error("kick transition did not clear watchdog");
	AST_WDOG_HOLD: assert property (rst_hi_oe |-> ##1 r.wdog == '0)
		else $error("watchdog advanced during reset");
	AST_WDOG_FIRE: assert property (r.st == ST_RUN && !$changed(kick_f)
		&& r.wdog == CNT_W'(WDOG_CYC - 1) && r.sup_ok |=> rst_hi_oe && rst_lo_n_oe && r.tmo == '0)
		else $error("watchdog expiry did not assert reset");
	AST_RELEASE: assert property (r.st == ST_TIMEOUT && r.tmo == CNT_W'(RST_CYC - 1) && r.sup_ok
		|=> !rst_hi_oe && !rst_lo_n_oe)
		else $error("reset not released after timeout");
	AST_HOLD_TIMEOUT: assert property ($rose(r.st == ST_TIMEOUT) |-> rst_hi_oe [*8])
		else $error("reset released too early");
	AST_BROWNOUT: assert property (!supply_ok [*2] |-> ##[1:6] (rst_hi_oe && rst_lo_n_oe))
		else $error("supply drop did not assert reset");
	AST_MANUAL: assert property (man && r.st == ST_RUN && r.sup_ok |=> r.st == ST_TIMEOUT && r.tmo == '0)
		else $error("manual edge did not restart timeout");
	AST_WRITE_START: assert property (eng_req.write_stop && eng_stat.access_ok && !wp_f
		|=> eng_stat.write_busy && !eng_stat.access_ok)
		else $error("write cycle did not start");
	AST_WRITE_END: assert property (eng_stat.write_busy && r.wr == CNT_W'(WR_CYC - 1)
		|=> !eng_stat.write_busy)
		else $error("write cycle overran");
	AST_NO_ACK: assert property ((eng_stat.write_busy || rst_hi_oe) |=> !sda_oe)
		else $error("acknowledge given while locked out");
	AST_WP: assert property (wp_f && eng_req.ack_wdata && !eng_req.ack_addr && !eng_req.drive_low
		|=> !sda_oe)
		else $error("write data acknowledged under write protect");

	COV_WDOG: cover property (wd_fire);
	COV_MANUAL: cover property (man && r.st == ST_RUN);
	COV_WRITE: cover property ($fell(eng_stat.write_busy));
	COV_BROWN: cover property (r.st == ST_RUN ##1 r.st == ST_POWER);
endmodule

// ===== dv/host_model.sv
// Host side of the supervisor: pull resistors on the reset pins, push buttons, watchdog kicker.
// Assumes the bench changes press_hi, press_lo and kick_en just after clk rises.
`timescale 1ns/1ps
module host_model #(
	parameter int unsigned KICK_GAP = 16
) (
	input  wire logic clk,
	input  wire logic rst_hi_oe,
	input  wire logic rst_lo_n_oe,
	input  wire logic rst_hi_o,
	input  wire logic rst_lo_n_o,
	input  wire logic press_hi,
	input  wire logic press_lo,
	input  wire logic kick_en,
	output logic      rst_hi_pin,
	output logic      rst_lo_n_pin,
	output logic      kick
);
	int unsigned gap_r = 0;
	logic        kick_r = 1'b0;
	// Pull-down on the high pin, pull-up on the low pin
	assign rst_hi_pin   = (rst_hi_oe & rst_hi_o) | press_hi;
	assign rst_lo_n_pin = ~((rst_lo_n_oe & ~rst_lo_n_o) | press_lo);
	assign kick         = kick_r;
	always @(posedge clk) begin
		if (kick_en) begin
			gap_r <= (gap_r == KICK_GAP - 1) ? 0 : gap_r + 1;
			if (gap_r == KICK_GAP - 1) begin
				kick_r <= ~kick_r;
			end
		end
	end
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the reset supervisor with shortened interval counts.
// Assumes host_model stands on the reset pins and the watchdog pin.
`timescale 1ns/1ps
module testbench;
	import sup_pkg::*;
	localparam int WD = 200;
	localparam int RC = 100;
	localparam int WC = 50;
	localparam eng_req_t REQ_STOP  = 4'h8;
	localparam eng_req_t REQ_ADDR  = 4'h4;
	localparam eng_req_t REQ_WDATA = 4'h2;
	localparam eng_req_t REQ_LOW   = 4'h1;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       supply_ok = 1'b0;
	logic       write_protect = 1'b0;
	logic       scl_i = 1'b1;
	logic       host_sda = 1'b1;
	logic       press_hi = 1'b0;
	logic       press_lo = 1'b0;
	logic       kick_en = 1'b1;
	eng_req_t   eng_req = '0;
	eng_stat_t  eng_stat;
	logic       rst_hi_oe, rst_lo_n_oe, rst_hi_i, rst_lo_n_i, kick;
	logic       sda_oe, scl_filt, sda_filt, sda_o, rst_hi_o, rst_lo_n_o;
	wire logic  sda_pin = host_sda & ~(sda_oe & ~sda_o);
	int         err_total = 0;
	int         cmp_count = 0;
	int         cyc_cnt = 0;
	int         n;
	supervisor_reset_watchdog_lockout #(.WDOG_CYC(WD), .RST_CYC(RC), .WR_CYC(WC))
	i_supervisor_reset_watchdog_lockout (.clk(clk), .resetn(resetn), .supply_ok(supply_ok),
		.watchdog_kick_input(kick), .write_protect(write_protect), .rst_hi_i(rst_hi_i), .rst_hi_o(rst_hi_o),
		.rst_hi_oe(rst_hi_oe), .rst_lo_n_i(rst_lo_n_i), .rst_lo_n_o(rst_lo_n_o), .rst_lo_n_oe(rst_lo_n_oe),
		.scl_i(scl_i), .sda_i(sda_pin), .sda_o(sda_o), .sda_oe(sda_oe), .scl_filt(scl_filt),
		.sda_filt(sda_filt), .eng_req(eng_req), .eng_stat(eng_stat));
	host_model i_host_model (.clk(clk), .rst_hi_oe(rst_hi_oe), .rst_lo_n_oe(rst_lo_n_oe),
		.rst_hi_o(rst_hi_o), .rst_lo_n_o(rst_lo_n_o),
		.press_hi(press_hi), .press_lo(press_lo), .kick_en(kick_en), .rst_hi_pin(rst_hi_i),
		.rst_lo_n_pin(rst_lo_n_i), .kick(kick));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask
	task automatic wait_oe(input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (rst_hi_oe !== lvl && cnt < lim) begin
			cyc(1);
			cnt++;
		end
		chk(rst_lo_n_oe, lvl);
	endtask
	task automatic t_power();
		cyc(20);
		chk(rst_hi_oe, 1'b1);
		supply_ok = 1'b1;
		wait_oe(1'b0, RC + 40, n);
		chk(n >= RC && n <= RC + 12, 1'b1);
		chk({rst_hi_i, rst_lo_n_i}, 2'b01);
		$display("test power done");
	endtask
	task automatic t_engine();
		// Bus traffic only once the device grants access
		n = 0;
		while (eng_stat.access_ok !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		eng_req = REQ_ADDR;
		cyc(1);
		chk(sda_oe, 1'b1);
		eng_req = REQ_STOP;
		cyc(1);
		eng_req = REQ_ADDR;
		chk({eng_stat.write_busy, eng_stat.access_ok}, 2'b10);
		cyc(2);
		chk(sda_oe, 1'b0);
		chk(sda_pin, 1'b1);
		n = 3;
		while (eng_stat.write_busy !== 1'b0 && n < WC + 20) begin
			cyc(1);
			n++;
		end
		chk(n >= WC && n <= WC + 2, 1'b1);
		write_protect = 1'b1;
		eng_req = '0;
		cyc(12);
		eng_req = REQ_WDATA;
		cyc(1);
		chk(sda_oe, 1'b0);
		eng_req = REQ_LOW;
		cyc(1);
		chk(sda_oe, 1'b1);
		eng_req = REQ_STOP;
		cyc(1);
		eng_req = '0;
		cyc(1);
		chk(eng_stat.write_busy, 1'b0);
		write_protect = 1'b0;
		cyc(12);
		eng_req.ack_wdata = 1'b1;
		cyc(1);
		chk(sda_oe, 1'b1);
		eng_req = '0;
		cyc(2);
		$display("test engine done");
	endtask
	task automatic t_noise();
		for (int i = 0; i < 2; i++) begin
			if (i == 0) scl_i = 1'b0; else host_sda = 1'b0;
			cyc(4);
			scl_i = 1'b1;
			host_sda = 1'b1;
			cyc(14);
			chk({scl_filt, sda_filt}, 2'b11);
			if (i == 0) scl_i = 1'b0; else host_sda = 1'b0;
			cyc(20);
			chk(i == 0 ? scl_filt : sda_filt, 1'b0);
			scl_i = 1'b1;
			host_sda = 1'b1;
			cyc(20);
		end
		$display("test noise done");
	endtask
	task automatic t_manual();
		for (int i = 0; i < 2; i++) begin
			// Filters settle after own release
			cyc(12);
			if (i == 0) press_hi = 1'b1; else press_lo = 1'b1;
			cyc(4);
			press_hi = 1'b0;
			press_lo = 1'b0;
			cyc(20);
			chk(rst_hi_oe, 1'b0);
			if (i == 0) press_hi = 1'b1; else press_lo = 1'b1;
			cyc(12);
			press_hi = 1'b0;
			press_lo = 1'b0;
			wait_oe(1'b1, 20, n);
			chk(rst_hi_oe, 1'b1);
			wait_oe(1'b0, RC + 20, n);
			chk(n >= RC - 14 && n <= RC + 4, 1'b1);
		end
		$display("test manual done");
	endtask
	task automatic t_wdog();
		cyc(3 * WD);
		chk(rst_hi_oe, 1'b0);
		kick_en = 1'b0;
		wait_oe(1'b1, WD + 40, n);
		chk(n >= WD - 16 && n <= WD + 12, 1'b1);
		chk({rst_hi_i, rst_lo_n_i}, 2'b10);
		wait_oe(1'b0, RC + 20, n);
		chk(n >= RC && n <= RC + 4, 1'b1);
		wait_oe(1'b1, WD + 20, n);
		chk(n >= WD && n <= WD + 4, 1'b1);
		wait_oe(1'b0, RC + 20, n);
		kick_en = 1'b1;
		chk({rst_hi_i, rst_lo_n_i}, 2'b01);
		$display("test watchdog done");
	endtask
	task automatic t_brown();
		supply_ok = 1'b0;
		wait_oe(1'b1, TRD_CYCLES, n);
		chk(rst_hi_oe, 1'b1);
		eng_req.ack_addr = 1'b1;
		cyc(30);
		chk({sda_oe, eng_stat.access_ok, rst_hi_oe}, 3'b001);
		eng_req = '0;
		supply_ok = 1'b1;
		wait_oe(1'b0, RC + 40, n);
		chk(rst_hi_oe, 1'b0);
		$display("test brownout done");
	endtask
	initial begin
		cyc(16);
		resetn = 1'b1;
		t_power();
		t_engine();
		t_noise();
		t_manual();
		t_wdog();
		t_brown();
		give_verdict();
	end
endmodule
